// [bench/mmsa_core_tb_top.sv]
// Self-checking bench for the memory addressing block
`include "mmsa_defs.svh"
`default_nettype none
module mmsa_core_tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  logic               ref_clk;
  logic               rst_b;
  logic               op_valid;
  mmsa_pkg::mmsa_op_t op_code;
  logic [7:0]         op_addr;
  logic [7:0]         op_wdata;
  logic [2:0]         op_bit;
  logic [11:0]        op_target;
  logic               pc_advance;
  logic               irq_i2c_req;
  logic               irq_tmr2_req;
  logic [15:0]        pmem_rdata;
  logic [11:0]        pc;
  logic [11:0]        lookup_addr;
  logic [7:0]         rd_data;
  logic               rd_valid;
  logic               busy;
  logic [7:0]         working_register;
  logic               stack_full;
  logic               stack_empty;
  logic               irq_ack_i2c;
  logic               irq_ack_tmr2;
  int                 n_mismatch;
  int                 n_tests;

  mmsa_core u_mmsa_core (
    .ref_clk          (ref_clk),
    .rst_b            (rst_b),
    .op_valid         (op_valid),
    .op_code          (op_code),
    .op_addr          (op_addr),
    .op_wdata         (op_wdata),
    .op_bit           (op_bit),
    .op_target        (op_target),
    .pc_advance       (pc_advance),
    .irq_i2c_req      (irq_i2c_req),
    .irq_tmr2_req     (irq_tmr2_req),
    .pmem_rdata       (pmem_rdata),
    .pc               (pc),
    .lookup_addr      (lookup_addr),
    .rd_data          (rd_data),
    .rd_valid         (rd_valid),
    .busy             (busy),
    .working_register (working_register),
    .stack_full       (stack_full),
    .stack_empty      (stack_empty),
    .irq_ack_i2c      (irq_ack_i2c),
    .irq_ack_tmr2     (irq_ack_tmr2)
  );

  initial ref_clk = 1'b0;
  always #10 ref_clk = ~ref_clk;

  // Content differs per address so a wrong table address shows up
  function automatic logic [15:0] rom_word(logic [11:0] a);
    return {a[11:4] ^ 8'h5A, ~a[7:0]};
  endfunction

  function automatic logic [11:0] lk_addr(logic last, logic [11:0] p,
                                          logic [7:0] ptr);
    return {last ? 4'hF : p[11:8], ptr};
  endfunction

  function automatic logic [7:0] gp_addr();
    return 8'(8'h42 + $urandom_range(0, 189));
  endfunction

  always_comb pmem_rdata = rom_word(lookup_addr);

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(string what, logic [15:0] seen, logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // One idle cycle after each request keeps op_valid to one write a step
  task automatic op(mmsa_pkg::mmsa_op_t c, logic [7:0] a, logic [7:0] d,
                    logic [2:0] b, logic [11:0] t);
    @(negedge ref_clk);
    op_valid = 1'b1;
    op_code = c;
    op_addr = a;
    op_wdata = d;
    op_bit = b;
    op_target = t;
    @(negedge ref_clk);
    op_valid = 1'b0;
  endtask

  task automatic wr(logic [7:0] a, logic [7:0] d);
    op(mmsa_pkg::OP_WRITE, a, d, 3'h0, 12'h000);
  endtask

  task automatic rdchk(string what, logic [7:0] a, logic [7:0] exp);
    op(mmsa_pkg::OP_LOAD_W, a, 8'h00, 3'h0, 12'h000);
    chk(what, {rd_valid, rd_data}, {1'b1, exp});
  endtask

  task automatic wait_ack(logic tmr, logic [11:0] vec);
    int i;
    for (i = 0; i < 20; i++) begin
      @(negedge ref_clk);
      if ((tmr ? irq_ack_tmr2 : irq_ack_i2c) === 1'b1) break;
    end
    if (i == 20) begin
      n_mismatch++;
      $display("CHECK FAILED irq_ack expected 1 seen 0");
      end_of_test();
    end
    chk("irq_pc", pc, vec);
    if (tmr) irq_tmr2_req = 1'b0;
    else irq_i2c_req = 1'b0;
  endtask

  initial begin
    repeat (20000) @(posedge ref_clk);
    n_mismatch++;
    $display("CHECK FAILED run_time expected end seen hang");
    end_of_test();
  end

  initial begin
    logic [7:0]  a;
    logic [7:0]  d;
    logic [2:0]  b;
    logic [11:0] t;
    logic [11:0] cur;
    logic [15:0] w;
    logic [11:0] q[$];
    int          k;
    rst_b = 1'b0;
    op_valid = 1'b0;
    op_code = mmsa_pkg::OP_NONE;
    op_addr = 8'h00;
    op_wdata = 8'h00;
    op_bit = 3'h0;
    op_target = 12'h000;
    pc_advance = 1'b0;
    irq_i2c_req = 1'b0;
    irq_tmr2_req = 1'b0;
    void'($urandom(32'hAFEF94A6));
    repeat (6) @(negedge ref_clk);
    rst_b = 1'b1;
    chk("stack_state", {stack_full, stack_empty, busy}, 3'b010);
    $display("test reset done");

    for (k = 0; k < 8; k++) begin
      a = (k == 0) ? 8'h40 : (k == 1) ? 8'hFF : gp_addr();
      d = 8'($urandom);
      wr(a, d);
      rdchk("gp_ram", a, d);
      chk("w_after_load", working_register, d);
    end
    d = 8'($urandom);
    op(mmsa_pkg::OP_LOAD_IMM, 8'h00, d, 3'h0, 12'h000);
    chk("w_imm", working_register, d);
    rdchk("w_at_05", `MMSA_ADDR_WREG, d);
    a = gp_addr();
    op(mmsa_pkg::OP_STORE_W, a, 8'h00, 3'h0, 12'h000);
    rdchk("store_w", a, d);
    wr(`MMSA_ADDR_WREG, ~d);
    chk("w_write", working_register, 8'(~d));
    $display("test ram done");

    for (k = 0; k < 5; k++) begin
      a = (k == 0) ? 8'h04 : (k == 1) ? 8'h09 : (k == 2) ? 8'h3F
          : 8'(8'h09 + $urandom_range(0, 54));
      wr(a, 8'hFF);
      rdchk("unimpl", a, 8'h00);
    end
    $display("test unimplemented done");

    for (k = 0; k < 2; k++) begin
      a = gp_addr();
      d = 8'($urandom);
      wr(k ? `MMSA_ADDR_PTR_B : `MMSA_ADDR_PTR_A, a);
      wr(k ? `MMSA_ADDR_IND_B : `MMSA_ADDR_IND_A, d);
      rdchk("ind_write", a, d);
      wr(a, ~d);
      rdchk("ind_read", k ? `MMSA_ADDR_IND_B : `MMSA_ADDR_IND_A, ~d);
    end
    for (k = 0; k < 4; k++) begin
      a = k[0] ? `MMSA_ADDR_PTR_B : `MMSA_ADDR_PTR_A;
      d = k[1] ? `MMSA_ADDR_IND_B : `MMSA_ADDR_IND_A;
      wr(a, d);
      wr(a - 8'h01, 8'h5A);
      rdchk("ind_self", a - 8'h01, 8'h00);
      rdchk("pointer", a, d);
    end
    wr(`MMSA_ADDR_PTR_A, 8'hFF);
    rdchk("ptr_width", `MMSA_ADDR_PTR_A, 8'hFF);
    $display("test indirect done");

    for (k = 0; k < 4; k++) begin
      a = gp_addr();
      d = 8'($urandom);
      b = 3'($urandom);
      wr(a, d);
      op(mmsa_pkg::OP_BIT_SET, a, 8'h00, b, 12'h000);
      d = d | (8'h01 << b);
      rdchk("bit_set", a, d);
      op(mmsa_pkg::OP_BIT_FORCE_LOW, a, 8'h00, b, 12'h000);
      d = d & ~(8'h01 << b);
      rdchk("bit_clear", a, d);
    end
    $display("test bits done");

    for (k = 0; k < 2; k++) begin
      t = 12'($urandom);
      op(mmsa_pkg::OP_JUMP, 8'h00, 8'h00, 3'h0, t);
      d = 8'($urandom);
      wr(`MMSA_ADDR_LKP, d);
      rdchk("lookup_pointer", `MMSA_ADDR_LKP, d);
      wr(8'h41, 8'h33);
      a = gp_addr();
      w = rom_word(lk_addr(k[0], t, d));
      @(negedge ref_clk);
      op_valid = 1'b1;
      op_code = k ? mmsa_pkg::OP_LOOKUP_LAST : mmsa_pkg::OP_LOOKUP_CUR;
      op_addr = a;
      @(negedge ref_clk);
      chk("busy_c1", busy, 1'b1);
      chk("lookup_addr", lookup_addr, lk_addr(k[0], t, d));
      // Request during busy must be ignored
      op_code = mmsa_pkg::OP_WRITE;
      op_addr = 8'h41;
      op_wdata = 8'hCC;
      @(negedge ref_clk);
      op_valid = 1'b0;
      chk("busy_c2", busy, 1'b0);
      rdchk("lookup_low", a, w[7:0]);
      rdchk("lookup_high", `MMSA_ADDR_LKH, w[15:8]);
      rdchk("busy_refused", 8'h41, 8'h33);
      wr(`MMSA_ADDR_LKH, ~w[15:8]);
      rdchk("lookup_high_ro", `MMSA_ADDR_LKH, w[15:8]);
    end
    $display("test lookup done");

    t = 12'($urandom);
    d = 8'($urandom);
    op(mmsa_pkg::OP_JUMP, 8'h00, 8'h00, 3'h0, t);
    wr(`MMSA_ADDR_PCL, d);
    chk("pcl_jump", pc, {t[11:8], d});
    rdchk("pcl_read", `MMSA_ADDR_PCL, d);
    @(negedge ref_clk);
    pc_advance = 1'b1;
    repeat (3) @(negedge ref_clk);
    pc_advance = 1'b0;
    chk("pc_advance", pc, 12'({t[11:8], d} + 12'h003));
    $display("test pcl done");

    cur = 12'($urandom);
    op(mmsa_pkg::OP_JUMP, 8'h00, 8'h00, 3'h0, cur);
    for (k = 0; k < 9; k++) begin
      t = 12'($urandom);
      q.push_back(cur);
      if (q.size() > 8) void'(q.pop_front());
      op(mmsa_pkg::OP_CALL, 8'h00, 8'h00, 3'h0, t);
      chk("call_pc", pc, t);
      chk("stack_full", stack_full, k >= 7);
      cur = t;
    end
    @(negedge ref_clk);
    irq_tmr2_req = 1'b1;
    repeat (6) begin
      @(negedge ref_clk);
      chk("ack_held", irq_ack_tmr2, 1'b0);
    end
    op(mmsa_pkg::OP_SUB_EXIT, 8'h00, 8'h00, 3'h0, 12'h000);
    cur = q.pop_back();
    chk("exit_pc", pc, cur);
    wait_ack(1'b1, `MMSA_VEC_TMR2);
    op(mmsa_pkg::OP_INT_EXIT, 8'h00, 8'h00, 3'h0, 12'h000);
    chk("int_exit_pc", pc, cur);
    while (q.size() > 0) begin
      op(mmsa_pkg::OP_SUB_EXIT, 8'h00, 8'h00, 3'h0, 12'h000);
      cur = q.pop_back();
      chk("pop_order", pc, cur);
    end
    chk("stack_empty", stack_empty, 1'b1);
    $display("test stack done");

    @(negedge ref_clk);
    irq_i2c_req = 1'b1;
    irq_tmr2_req = 1'b1;
    wait_ack(1'b0, `MMSA_VEC_I2C);
    chk("tmr2_waits", irq_ack_tmr2, 1'b0);
    wait_ack(1'b1, `MMSA_VEC_TMR2);
    op(mmsa_pkg::OP_INT_EXIT, 8'h00, 8'h00, 3'h0, 12'h000);
    chk("nest_exit", pc, `MMSA_VEC_I2C);
    op(mmsa_pkg::OP_INT_EXIT, 8'h00, 8'h00, 3'h0, 12'h000);
    chk("irq_return", pc, cur);
    $display("test interrupts done");
    end_of_test();
  end
endmodule
`default_nettype wire

// [hdl/mmsa_core.sv]
// Data memory map, indirect access, table lookup and return stack
`include "mmsa_defs.svh"
`default_nettype none

// What this block does
// - Acknowledged enabled I2C interrupt with stack room jumps to 014H.
// - Acknowledged enabled third timer overflow with stack room jumps to 018H.
// - Current-page lookup address is PC[11:8] above the 8-bit lookup pointer.
// - Last-page lookup address is 1111 above the 8-bit lookup pointer.
// - Lookup puts low byte in chosen location, upper byte in register 08H.
// - Lookup pointer is read/write at 07H, loaded by software beforehand.
// - Every lookup read takes two cycles.
// - Stack holds eight PC entries, hidden from software and both spaces.
// - Call and interrupt push PC; both exit kinds pop it back.
// - Reset leaves the stack index at top, stack empty.
// - Full stack holds off interrupt acknowledge until an exit pops.
// - Call on full stack drops the oldest entry, keeping eight newest.
// - Unimplemented addresses below 40H read 00H.
// - Addresses below 40H are the same special space in every bank.
// - General purpose memory spans 40H to FFH, read and write.
// - Bit set and bit clear work on any non-dedicated data bit.
// - Address 00H reaches pointer 01H target, 02H reaches pointer 03H target.
// - Indirect access to 00H or 02H reads 00H and ignores writes.
// - Both indirect pointers are eight bits wide.
// - Working register sits at 05H and takes immediate operands.
// - Memory to memory moves go only through the working register.
// - Program counter low byte at 06H; writing it jumps within the page.
module mmsa_core (
  input  wire logic             ref_clk,
  input  wire logic             rst_b,
  input  wire logic             op_valid,
  input  wire mmsa_pkg::mmsa_op_t op_code,
  input  wire logic [7:0]       op_addr,
  input  wire logic [7:0]       op_wdata,
  input  wire logic [2:0]       op_bit,
  input  wire logic [11:0]      op_target,
  input  wire logic             pc_advance,
  input  wire logic             irq_i2c_req,
  input  wire logic             irq_tmr2_req,
  input  wire logic [15:0]      pmem_rdata,
  output logic      [11:0]      pc,
  output logic      [11:0]      lookup_addr,
  output logic      [7:0]       rd_data,
  output logic                  rd_valid,
  output logic                  busy,
  output logic      [7:0]       working_register,
  output logic                  stack_full,
  output logic                  stack_empty,
  output logic                  irq_ack_i2c,
  output logic                  irq_ack_tmr2
);

  mmsa_pkg::mmsa_state_t state_q;

  logic [7:0]  gp_ram_q [`MMSA_GP_WORDS];
  logic [11:0] stack_q  [`MMSA_STACK_DEPTH];
  logic [2:0]  stack_index_q;
  logic [3:0]  depth_q;
  logic [7:0]  indirect_pointer_a_q;
  logic [7:0]  indirect_pointer_b_q;
  logic [7:0]  lookup_pointer_q;
  logic [7:0]  lookup_high_byte_q;
  logic [7:0]  lk_dest_q;
  logic        lk_self_q;

  // Request decode
  wire        idle       = (state_q == mmsa_pkg::ST_IDLE);
  wire        take       = op_valid & idle;
  wire        in_lookup  = (state_q == mmsa_pkg::ST_LOOKUP);
  wire        op_lkc     = (op_code == mmsa_pkg::OP_LOOKUP_CUR);
  wire        op_lkl     = (op_code == mmsa_pkg::OP_LOOKUP_LAST);
  wire        op_call    = (op_code == mmsa_pkg::OP_CALL);
  wire        op_jump    = (op_code == mmsa_pkg::OP_JUMP);
  wire        op_exit    = (op_code == mmsa_pkg::OP_SUB_EXIT) |
                           (op_code == mmsa_pkg::OP_INT_EXIT);
  wire        op_load_w  = (op_code == mmsa_pkg::OP_LOAD_W);
  wire        op_imm     = (op_code == mmsa_pkg::OP_LOAD_IMM);
  wire        op_store_w = (op_code == mmsa_pkg::OP_STORE_W);
  wire        op_write   = (op_code == mmsa_pkg::OP_WRITE);
  wire        op_bset    = (op_code == mmsa_pkg::OP_BIT_SET);
  wire        op_bclr    = (op_code == mmsa_pkg::OP_BIT_FORCE_LOW);

  // Indirect windows resolve through their pointers
  wire        is_ind_a   = (op_addr == `MMSA_ADDR_IND_A);
  wire        is_ind_b   = (op_addr == `MMSA_ADDR_IND_B);
  wire [7:0]  eff_addr   = is_ind_a ? indirect_pointer_a_q :
                           is_ind_b ? indirect_pointer_b_q :
                           op_addr;
  wire        eff_window = (eff_addr == `MMSA_ADDR_IND_A) |
                           (eff_addr == `MMSA_ADDR_IND_B);
  // A window pointing at a window would chain forever; it is made dead
  wire        self_ind   = eff_window;

  // No bank bits enter the decode, so low space is common to all banks
  wire        gp_hit     = (eff_addr >= `MMSA_GP_BASE);
  wire [7:0]  gp_idx     = eff_addr - `MMSA_GP_BASE;

  wire [7:0]  mem_rd =
    self_ind                         ? `MMSA_READ_ZERO :
    gp_hit                           ? gp_ram_q[gp_idx] :
    (eff_addr == `MMSA_ADDR_PTR_A)   ? indirect_pointer_a_q :
    (eff_addr == `MMSA_ADDR_PTR_B)   ? indirect_pointer_b_q :
    (eff_addr == `MMSA_ADDR_WREG)    ? working_register :
    (eff_addr == `MMSA_ADDR_PCL)     ? pc[7:0] :
    (eff_addr == `MMSA_ADDR_LKP)     ? lookup_pointer_q :
    (eff_addr == `MMSA_ADDR_LKH)     ? lookup_high_byte_q :
                                       `MMSA_READ_ZERO;

  // Read-modify-write for single bit operations
  wire [7:0]  bit_mask = `MMSA_BIT_ONE << op_bit;
  wire [7:0]  bit_val  = op_bset ? (mem_rd | bit_mask)
                                 : (mem_rd & ~bit_mask);

  // Only one data operand per request: copies go via working register
  wire        op_mem_wr = op_store_w | op_write | op_bset | op_bclr;
  wire        wr_en   = (take & op_mem_wr & ~self_ind) |
                        (in_lookup & ~lk_self_q);
  wire [7:0]  wr_addr = in_lookup ? lk_dest_q : eff_addr;
  wire [7:0]  wr_data = in_lookup  ? pmem_rdata[7:0] :
                        op_store_w ? working_register :
                        op_write   ? op_wdata :
                        bit_val;
  wire        wr_gp   = wr_en & (wr_addr >= `MMSA_GP_BASE);
  wire [7:0]  wr_idx  = wr_addr - `MMSA_GP_BASE;
  wire        wr_pcl  = wr_en & (wr_addr == `MMSA_ADDR_PCL);
  wire        wr_wreg = wr_en & (wr_addr == `MMSA_ADDR_WREG);

  // Stack bookkeeping; index wraps so overflow overwrites the oldest
  wire [2:0]  sp_below  = stack_index_q - `MMSA_SP_STEP;
  wire [11:0] stack_top = stack_q[sp_below];
  wire        full      = (depth_q == `MMSA_STACK_DEPTH);
  wire        irq_any   = irq_i2c_req | irq_tmr2_req;
  // Interrupts wait for a free slot and for a quiet sequencer cycle
  wire        irq_take  = idle & ~op_valid & irq_any & ~full;
  wire        irq_i2c   = irq_take & irq_i2c_req;
  wire        irq_tmr2  = irq_take & ~irq_i2c_req;
  wire        push      = (take & op_call) | irq_take;
  wire        pop       = take & op_exit;

  wire [11:0] lk_addr_d = op_lkl ? {`MMSA_LAST_PAGE, lookup_pointer_q}
                                 : {pc[11:8], lookup_pointer_q};

  // Sequencer state: a lookup occupies one extra cycle
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      state_q <= mmsa_pkg::ST_IDLE;
    end else if (take & (op_lkc | op_lkl)) begin
      state_q <= mmsa_pkg::ST_LOOKUP;
    end else begin
      state_q <= mmsa_pkg::ST_IDLE;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      busy <= 1'b0;
    end else begin
      busy <= take & (op_lkc | op_lkl);
    end
  end

  // Lookup address and destination captured on acceptance
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      lookup_addr <= `MMSA_VEC_RESET;
      lk_dest_q   <= `MMSA_RST_BYTE;
      lk_self_q   <= 1'b0;
    end else if (take & (op_lkc | op_lkl)) begin
      lookup_addr <= lk_addr_d;
      lk_dest_q   <= eff_addr;
      lk_self_q   <= self_ind;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      lookup_high_byte_q <= `MMSA_RST_BYTE;
    end else if (in_lookup) begin
      lookup_high_byte_q <= pmem_rdata[15:8];
    end
  end

  // Pointer registers; the high byte register ignores writes
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      indirect_pointer_a_q <= `MMSA_RST_BYTE;
      indirect_pointer_b_q <= `MMSA_RST_BYTE;
      lookup_pointer_q     <= `MMSA_RST_BYTE;
    end else if (wr_en) begin
      if (wr_addr == `MMSA_ADDR_PTR_A) begin
        indirect_pointer_a_q <= wr_data;
      end
      if (wr_addr == `MMSA_ADDR_PTR_B) begin
        indirect_pointer_b_q <= wr_data;
      end
      if (wr_addr == `MMSA_ADDR_LKP) begin
        lookup_pointer_q <= wr_data;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      working_register <= `MMSA_RST_BYTE;
    end else if (take & op_imm) begin
      working_register <= op_wdata;
    end else if (take & op_load_w) begin
      working_register <= mem_rd;
    end else if (wr_wreg) begin
      working_register <= wr_data;
    end
  end

  // General purpose storage, no reset: contents undefined at power up
  always_ff @(posedge ref_clk) begin
    if (wr_gp) begin
      gp_ram_q[wr_idx] <= wr_data;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      rd_data  <= `MMSA_RST_BYTE;
      rd_valid <= 1'b0;
    end else begin
      rd_data  <= (take & op_load_w) ? mem_rd : rd_data;
      rd_valid <= take & op_load_w;
    end
  end

  // Program counter: control transfers outrank the plain increment
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      pc <= `MMSA_VEC_RESET;
    end else if (irq_i2c) begin
      pc <= `MMSA_VEC_I2C;
    end else if (irq_tmr2) begin
      pc <= `MMSA_VEC_TMR2;
    end else if (take & (op_call | op_jump)) begin
      pc <= op_target;
    end else if (pop) begin
      pc <= stack_top;
    end else if (wr_pcl) begin
      pc <= {pc[11:8], wr_data};
    end else if (pc_advance) begin
      pc <= pc + `MMSA_PC_STEP;
    end
  end

  // Stack storage is never on the data path
  always_ff @(posedge ref_clk) begin
    if (push) begin
      stack_q[stack_index_q] <= pc;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      stack_index_q <= `MMSA_SP_TOP;
      depth_q       <= `MMSA_STACK_EMPTY;
    end else if (push) begin
      stack_index_q <= stack_index_q + `MMSA_SP_STEP;
      depth_q       <= full ? depth_q : depth_q + `MMSA_STACK_STEP;
    end else if (pop && depth_q != `MMSA_STACK_EMPTY) begin
      stack_index_q <= sp_below;
      depth_q       <= depth_q - `MMSA_STACK_STEP;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      stack_full   <= 1'b0;
      stack_empty  <= 1'b1;
      irq_ack_i2c  <= 1'b0;
      irq_ack_tmr2 <= 1'b0;
    end else begin
      stack_full   <= push ? (full | (depth_q == `MMSA_STACK_DEPTH -
                                      `MMSA_STACK_STEP))
                           : (pop ? 1'b0 : full);
      stack_empty  <= push ? 1'b0
                           : (pop ? (depth_q <= `MMSA_STACK_STEP)
                                  : (depth_q == `MMSA_STACK_EMPTY));
      irq_ack_i2c  <= irq_i2c;
      irq_ack_tmr2 <= irq_tmr2;
    end
  end

  // Checks
  sequence s_lookup_start;
    take & (op_lkc | op_lkl);
  endsequence

  sequence s_lookup_finish;
    busy ##1 !busy;
  endsequence

  a_vec_i2c_entry: assert property (@(posedge ref_clk)
    disable iff (!rst_b)
    irq_i2c |=> (pc == `MMSA_VEC_I2C) && irq_ack_i2c)
    else $error("I2C entry did not land on its vector");

  a_vec_tmr2_entry: assert property (@(posedge ref_clk)
    disable iff (!rst_b)
    irq_tmr2 |=> (pc == `MMSA_VEC_TMR2) && irq_ack_tmr2)
    else $error("Timer entry did not land on its vector");

  a_lookup_cur_addr: assert property (@(posedge ref_clk)
    disable iff (!rst_b)
    (take & op_lkc) |=> lookup_addr == {$past(pc[11:8]),
                                        $past(lookup_pointer_q)})
    else $error("Current page lookup address wrong");

  a_lookup_last_addr: assert property (@(posedge ref_clk)
    disable iff (!rst_b)
    (take & op_lkl) |=> lookup_addr == {`MMSA_LAST_PAGE,
                                        $past(lookup_pointer_q)})
    else $error("Last page lookup address wrong");

  a_lookup_high_cap: assert property (@(posedge ref_clk)
    disable iff (!rst_b)
    busy |=> lookup_high_byte_q == $past(pmem_rdata[15:8]))
    else $error("Lookup high byte not captured");

  // Software writes to the high byte register must be dropped
  a_lookup_high_ro: assert property (@(posedge ref_clk)
    disable iff (!rst_b)
    (take & op_mem_wr & (eff_addr == `MMSA_ADDR_LKH))
      |=> $stable(lookup_high_byte_q))
    else $error("Lookup high byte took a write");

  a_lookup_two_cyc: assert property (@(posedge ref_clk)
    disable iff (!rst_b)
    s_lookup_start |=> s_lookup_finish)
    else $error("Lookup did not take two cycles");

  a_stack_depth_cap: assert property (@(posedge ref_clk)
    disable iff (!rst_b)
    (depth_q <= `MMSA_STACK_DEPTH) && (stack_full == (depth_q ==
                                                     `MMSA_STACK_DEPTH)))
    else $error("Stack depth out of range");

  a_exit_restores_pc: assert property (@(posedge ref_clk)
    disable iff (!rst_b)
    pop |=> pc == $past(stack_top))
    else $error("Exit did not restore PC");

  a_reset_stack_empty: assert property (@(posedge ref_clk)
    !rst_b |=> (depth_q == `MMSA_STACK_EMPTY) && stack_empty)
    else $error("Stack not empty after reset");

  a_full_holds_irq: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (full && !pop) |=> !irq_ack_i2c && !irq_ack_tmr2)
    else $error("Interrupt acknowledged on full stack");

  a_overflow_keeps_eight: assert property (@(posedge ref_clk)
    disable iff (!rst_b)
    (take & op_call & full) |=> full && ($past(pc) ==
                                         stack_q[$past(stack_index_q)]))
    else $error("Overflow call lost newest entry");

  a_unmapped_reads_zero: assert property (@(posedge ref_clk)
    disable iff (!rst_b)
    (take & op_load_w & (eff_addr == `MMSA_ADDR_LKH + 8'h01))
      |=> working_register == `MMSA_READ_ZERO)
    else $error("Unimplemented address read nonzero");

  a_window_self_dead: assert property (@(posedge ref_clk)
    disable iff (!rst_b)
    (take & op_load_w & self_ind) |=> rd_valid && rd_data ==
                                      `MMSA_READ_ZERO)
    else $error("Window self access not zero");

  a_pcl_page_jump: assert property (@(posedge ref_clk)
    disable iff (!rst_b)
    (wr_pcl & ~push & ~pop & ~(take & (op_call | op_jump)))
      |=> pc == {$past(pc[11:8]), $past(wr_data)})
    else $error("PC low write left page");

endmodule
`default_nettype wire

// [inc/mmsa_defs.svh]
// Address map, vectors and sizes of the memory addressing block
`ifndef MMSA_DEFS_SVH
`define MMSA_DEFS_SVH

`define MMSA_ADDR_IND_A     8'h00
`define MMSA_ADDR_PTR_A     8'h01
`define MMSA_ADDR_IND_B     8'h02
`define MMSA_ADDR_PTR_B     8'h03
`define MMSA_ADDR_WREG      8'h05
`define MMSA_ADDR_PCL       8'h06
`define MMSA_ADDR_LKP       8'h07
`define MMSA_ADDR_LKH       8'h08
`define MMSA_GP_BASE        8'h40
`define MMSA_GP_WORDS       192
`define MMSA_READ_ZERO      8'h00
`define MMSA_RST_BYTE       8'h00
`define MMSA_BIT_ONE        8'h01

`define MMSA_VEC_RESET      12'h000
`define MMSA_VEC_I2C        12'h014
`define MMSA_VEC_TMR2       12'h018
`define MMSA_PC_STEP        12'h001
`define MMSA_LAST_PAGE      4'hF

`define MMSA_STACK_DEPTH    4'h8
`define MMSA_STACK_EMPTY    4'h0
`define MMSA_STACK_STEP     4'h1
`define MMSA_SP_STEP        3'h1
`define MMSA_SP_TOP         3'h0

`endif

// [inc/mmsa_pkg.sv]
// Types shared by the memory addressing block
`default_nettype none
package mmsa_pkg;

  typedef enum logic [3:0] {
    OP_NONE,
    OP_LOAD_W,
    OP_STORE_W,
    OP_WRITE,
    OP_LOAD_IMM,
    OP_BIT_SET,
    OP_BIT_FORCE_LOW,
    OP_LOOKUP_CUR,
    OP_LOOKUP_LAST,
    OP_CALL,
    OP_JUMP,
    OP_SUB_EXIT,
    OP_INT_EXIT
  } mmsa_op_t;

  typedef enum logic [0:0] {
    ST_IDLE,
    ST_LOOKUP
  } mmsa_state_t;

endpackage
`default_nettype wire
